// ===== rtl/ctdr_consts.svh
// Purpose: Offsets, field positions, reset values of the chip test registers
// Assumes: Printed offsets are word indexes; byte address is four times the index
// Notes:   Definitions only
`ifndef CTDR_CONSTS_SVH
`define CTDR_CONSTS_SVH

// ==========================================================================
// Register indexes and address width
`define CTDR_IDX_HANDSHAKE      6'h16
`define CTDR_IDX_FIFO_READOUT   6'h17
`define CTDR_IDX_TEST_MODE      6'h18
`define CTDR_IDX_PULSE          6'h19
`define CTDR_ADDR_W             8

// ==========================================================================
// Reset values
`define CTDR_RST_HANDSHAKE      8'h21
`define CTDR_RST_FIFO_READOUT   8'h00
`define CTDR_RST_TEST_MODE      8'h00
`define CTDR_RST_PULSE          8'h00

// ==========================================================================
// Handshake status fields
`define CTDR_HS_SOFTWARE_SIGNAL_FLAG            6
`define CTDR_HS_OFFSET_CMP      5
`define CTDR_HS_SFIFO_PAR       4
`define CTDR_HS_DFIFO_PAR       3
`define CTDR_HS_TRUE_END_OF_PROCESS            2
`define CTDR_HS_INTERNAL_DATA_REQUEST            1
`define CTDR_HS_INTERNAL_DATA_ACKNOWLEDGE            0

// ==========================================================================
// Test mode control fields
`define CTDR_TM_MUX             7
`define CTDR_TM_ALL_FLOAT       6
`define CTDR_TM_SCSI_FLOAT      5
`define CTDR_TM_LOOPBACK        4
`define CTDR_TM_REDIRECT        3
`define CTDR_TM_LANE_EN         2

// ==========================================================================
// Manual pulse control fields
`define CTDR_MP_ADDR_CLK        7
`define CTDR_MP_BCNT_CLK        6
`define CTDR_MP_OFF_RESET       5
`define CTDR_MP_MASTER_SR       4
`define CTDR_MP_DMA_DIR         3
`define CTDR_MP_EOP             2
`define CTDR_MP_INTERNAL_DATA_REQUEST            1
`define CTDR_MP_INTERNAL_DATA_ACKNOWLEDGE            0

// ==========================================================================
// SCSI synchronous FIFO geometry
`define CTDR_SFIFO_DEPTH        8
`define CTDR_SFIFO_PTR_W        3
`define CTDR_SFIFO_CNT_W        4

`endif

// ===== rtl/ctdr_pkg.sv
// Purpose: Types shared by the chip test register block
// Assumes: Constants live in ctdr_consts.svh
// Notes:   Register select is one-hot
package ctdr_pkg;

	// ======================================================================
	// Types
	typedef logic [7:0] ctdr_byte_t;

	typedef enum logic [4:0] {
		CTDR_SEL_NONE  = 5'b00001,
		CTDR_SEL_HS    = 5'b00010,
		CTDR_SEL_FIFO  = 5'b00100,
		CTDR_SEL_MODE  = 5'b01000,
		CTDR_SEL_PULSE = 5'b10000
	} ctdr_sel_t;

endpackage

// ===== rtl/ctdr_regs.sv
// Purpose: Diagnostic and test register group behind an APB slave
// Assumes: Core side signals arrive on pclk; no wait states beyond one access
// Notes:   Every output is a flip-flop
//
// Notes on behaviour
// R1: Status bit 6 mirrors signal flag; any status read clears it.
// R2: Offset compare: initiator at count zero, target at programmed maximum.
// R3: FIFO readout read latches popped byte's parity into status bit 4.
// R4: DMA FIFO data read latches that byte's parity into status bit 3.
// R5: Status bit 2 shows true end of process, active high.
// R6: Bit 1 shows data request active; bit 0 shows acknowledge inactive.
// R7: FIFO readout read returns bottom byte of eight-entry FIFO and pops it.
// R8: Readout read on empty FIFO raises gross error for underflow.
// R9: Mux bit selects multiplexed host bus; set before taking mastership.
// R10: All-float bit floats every output and two-way pin.
// R11: SCSI-float bit floats SCSI outputs; direction lines driven low.
// R12: Loopback lets any SCSI signal assert and returns output latch to input.
// R13: Redirect makes output latch writes push FIFO with selected parity.
// R14: Lane field top bit enables access; low bits pick lane zero to three.
// R15: Software clears lane enable before starting the script processor.
// R16: Address clock bit steps the next address pointer, then clears.
// R17: Byte counter clock bit steps the byte counter, then clears.
// R18: Offset reset bit clears offset counter; gross error sets it.
// R19: Master set/reset selects assert or deassert for bits three to zero.
// R20: Bit 3 drives DMA write direction per master set/reset.
// R21: Bit 2 pulses end of process when asserting, then clears.
// R22: Bits 1,0 drive data request and acknowledge; hold until deasserted.
// R23: Writes to read-only registers are ignored; reserved bits read zero.
`timescale 1ns/1ps
`include "ctdr_consts.svh"

module ctdr_regs
(
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic [`CTDR_ADDR_W-1:0]        paddr,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [31:0]                    pwdata,
	output      logic [31:0]                    prdata,
	output      logic                           pready,
	output      logic                           pslverr,
	input  wire logic                           software_signal_flag_flag,
	output      logic                           software_signal_flag_clear,
	input  wire logic [3:0]                     offset_count,
	input  wire logic [3:0]                     offset_max,
	input  wire logic                           role_initiator,
	input  wire logic                           true_end_of_process,
	input  wire logic                           core_data_request,
	input  wire logic                           core_data_ack_n,
	input  wire logic                           dfifo_rd_stb,
	input  wire logic                           dfifo_rd_parity,
	input  wire logic                           sfifo_push,
	input  wire logic [8:0]                     sfifo_push_word,
	input  wire logic                           scsi_output_data_latch_wr_stb,
	input  wire logic [7:0]                     scsi_output_data_latch_wr_data,
	input  wire logic                           scsi_even_parity,
	input  wire logic                           gross_error_in,
	output      logic                           gross_error_underflow,
	output      logic [`CTDR_SFIFO_CNT_W-1:0]   sfifo_count,
	output      logic                           bus_mux_mode,
	output      logic                           host_pins_oe,
	output      logic                           scsi_pins_oe,
	output      logic                           scsi_dir_force_low,
	output      logic                           loopback_enable,
	output      logic                           loop_scsi_input_data_latch_load,
	output      logic [7:0]                     loop_scsi_input_data_latch_data,
	output      logic                           lane_access_en,
	output      logic [1:0]                     lane_select,
	output      logic                           addr_step,
	output      logic                           bcnt_step,
	output      logic                           offset_clear,
	output      logic                           dma_write_direction,
	output      logic                           end_of_process,
	output      logic                           data_request_force,
	output      logic                           data_ack_force_n
);

	// ======================================================================
	// Bus decode
	ctdr_pkg::ctdr_sel_t    sel;
	logic                   setup;
	logic                   access;
	logic                   wr_acc;
	logic                   rd_acc;
	logic [7:0]             wbyte;
	logic [7:0]             status;
	logic [7:0]             mode_q;
	logic                   master_set_reset_q;
	logic [7:0]             pulse_rd;
	logic                   offset_compare_flag_q;
	logic                   sfp_q;
	logic                   dfp_q;
	logic [8:0]             sfifo_mem [`CTDR_SFIFO_DEPTH];
	logic [`CTDR_SFIFO_PTR_W-1:0] rd_ptr_q;
	logic [`CTDR_SFIFO_PTR_W-1:0] wr_ptr_q;
	logic [`CTDR_SFIFO_CNT_W-1:0] cnt_q;
	logic                   sf_empty;
	logic                   sf_full;
	logic                   pop;
	logic                   push;
	logic [8:0]             push_word;
	logic                   redirect_push;

	// Registered pready lets prdata come from a flop: one wait-free access
	assign setup  = psel & ~penable;
	assign access = psel & penable & pready;
	assign wr_acc = access & pwrite;
	assign rd_acc = access & ~pwrite;
	assign wbyte  = pwdata[7:0];

	// Word index decode; unaligned bytes are unmapped
	always_comb
	begin
		sel = ctdr_pkg::CTDR_SEL_NONE;
		if (paddr[1:0] == 2'h0)
		begin
			if (paddr[7:2] == `CTDR_IDX_HANDSHAKE)
				sel = ctdr_pkg::CTDR_SEL_HS;
			else if (paddr[7:2] == `CTDR_IDX_FIFO_READOUT)
				sel = ctdr_pkg::CTDR_SEL_FIFO;
			else if (paddr[7:2] == `CTDR_IDX_TEST_MODE)
				sel = ctdr_pkg::CTDR_SEL_MODE;
			else if (paddr[7:2] == `CTDR_IDX_PULSE)
				sel = ctdr_pkg::CTDR_SEL_PULSE;
		end
	end

	// ======================================================================
	// Status assembly
	always_comb
	begin
		status = 8'h00;                                        // Reserved reads zero [R23]
		status[`CTDR_HS_SOFTWARE_SIGNAL_FLAG]       = software_signal_flag_flag;               // [R1]
		status[`CTDR_HS_OFFSET_CMP] = offset_compare_flag_q;                  // [R2]
		status[`CTDR_HS_SFIFO_PAR]  = sfp_q;                   // [R3]
		status[`CTDR_HS_DFIFO_PAR]  = dfp_q;                   // [R4]
		status[`CTDR_HS_TRUE_END_OF_PROCESS]       = true_end_of_process;     // [R5]
		status[`CTDR_HS_INTERNAL_DATA_REQUEST]       = core_data_request | data_request_force;  // [R6]
		status[`CTDR_HS_INTERNAL_DATA_ACKNOWLEDGE]       = core_data_ack_n & data_ack_force_n;      // [R6]
	end

	// Pulse bits read back only while active; master set/reset holds
	assign pulse_rd = {addr_step, bcnt_step, offset_clear, master_set_reset_q, 4'h0};

	// APB answer: ready and data captured in setup; ready dropped after access, data held until next read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & (sel == ctdr_pkg::CTDR_SEL_NONE);
			if (setup & ~pwrite)
			begin
				unique case (sel)
					ctdr_pkg::CTDR_SEL_HS:    prdata <= {24'h00_0000, status};
					ctdr_pkg::CTDR_SEL_FIFO:                                     // [R7]
						prdata <= {24'h00_0000, sf_empty ? 8'h00 : sfifo_mem[rd_ptr_q][7:0]};
					ctdr_pkg::CTDR_SEL_MODE:  prdata <= {24'h00_0000, mode_q};
					ctdr_pkg::CTDR_SEL_PULSE: prdata <= {24'h00_0000, pulse_rd};
					ctdr_pkg::CTDR_SEL_NONE:  prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ======================================================================
	// Status side effects
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			software_signal_flag_clear <= 1'b0;
			offset_compare_flag_q     <= 1'(`CTDR_RST_HANDSHAKE >> `CTDR_HS_OFFSET_CMP);
			dfp_q      <= 1'b0;
		end
		else
		begin
			software_signal_flag_clear <= rd_acc & (sel == ctdr_pkg::CTDR_SEL_HS);        // [R1]
			offset_compare_flag_q     <= role_initiator ? (offset_count == 4'h0)
			                             : (offset_count == offset_max);  // [R2]
			if (dfifo_rd_stb)
				dfp_q <= dfifo_rd_parity;                                 // [R4]
		end
	end

	// ======================================================================
	// SCSI synchronous FIFO
	assign sf_empty      = (cnt_q == 4'h0);
	assign sf_full       = (cnt_q == 4'(`CTDR_SFIFO_DEPTH));
	assign pop           = rd_acc & (sel == ctdr_pkg::CTDR_SEL_FIFO) & ~sf_empty;   // [R7]
	assign redirect_push = scsi_output_data_latch_wr_stb & mode_q[`CTDR_TM_REDIRECT];               // [R13]
	// Odd parity unless even is asserted
	assign push_word     = redirect_push ?
	                       {scsi_even_parity ? ^scsi_output_data_latch_wr_data : ~^scsi_output_data_latch_wr_data,
	                        scsi_output_data_latch_wr_data} : sfifo_push_word;                      // [R13]
	// Full FIFO drops the push; the core must watch the count
	assign push          = (redirect_push | sfifo_push) & ~sf_full;

	always_ff @(posedge pclk)
	begin
		if (push)
			sfifo_mem[wr_ptr_q] <= push_word;
	end

	// Pointers, count, latched parity
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_ptr_q    <= 3'h0;
			wr_ptr_q    <= 3'h0;
			cnt_q       <= 4'h0;
			sfp_q       <= 1'b0;
			sfifo_count <= 4'h0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 3'h1;
			if (pop)
			begin
				rd_ptr_q <= rd_ptr_q + 3'h1;
				sfp_q    <= sfifo_mem[rd_ptr_q][8];                     // [R3]
			end
			cnt_q       <= cnt_q + {3'h0, push} - {3'h0, pop};
			sfifo_count <= cnt_q + {3'h0, push} - {3'h0, pop};
		end
	end

	// Underflow pulse towards the gross error logic
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gross_error_underflow <= 1'b0;
		else
			gross_error_underflow <= rd_acc & (sel == ctdr_pkg::CTDR_SEL_FIFO)
			                         & sf_empty;                              // [R8]
	end

	// ======================================================================
	// Test mode control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= `CTDR_RST_TEST_MODE;
		else if (wr_acc & (sel == ctdr_pkg::CTDR_SEL_MODE))
			mode_q <= wbyte;
	end

	// Pin controls; all-float overrides the SCSI-only float
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_mux_mode       <= 1'b0;
			host_pins_oe       <= 1'b1;
			scsi_pins_oe       <= 1'b1;
			scsi_dir_force_low <= 1'b0;
			loopback_enable    <= 1'b0;
			lane_access_en     <= 1'b0;
			lane_select        <= 2'h0;
		end
		else
		begin
			bus_mux_mode       <= mode_q[`CTDR_TM_MUX];                         // [R9]
			host_pins_oe       <= ~mode_q[`CTDR_TM_ALL_FLOAT];                  // [R10]
			scsi_pins_oe       <= ~(mode_q[`CTDR_TM_ALL_FLOAT]
			                        | mode_q[`CTDR_TM_SCSI_FLOAT]);              // [R10] [R11]
			scsi_dir_force_low <= mode_q[`CTDR_TM_SCSI_FLOAT]
			                      & ~mode_q[`CTDR_TM_ALL_FLOAT];                 // [R11]
			loopback_enable    <= mode_q[`CTDR_TM_LOOPBACK];                    // [R12]
			lane_access_en     <= mode_q[`CTDR_TM_LANE_EN];                     // [R14]
			lane_select        <= mode_q[1:0];                                  // [R14]
		end
	end

	// Loopback returns each output latch byte to the input latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			loop_scsi_input_data_latch_load <= 1'b0;
			loop_scsi_input_data_latch_data <= 8'h00;
		end
		else
		begin
			loop_scsi_input_data_latch_load <= scsi_output_data_latch_wr_stb & mode_q[`CTDR_TM_LOOPBACK];          // [R12]
			if (scsi_output_data_latch_wr_stb & mode_q[`CTDR_TM_LOOPBACK])
				loop_scsi_input_data_latch_data <= scsi_output_data_latch_wr_data;
		end
	end

	// ======================================================================
	// Manual pulse control
	logic pulse_wr;
	assign pulse_wr = wr_acc & (sel == ctdr_pkg::CTDR_SEL_PULSE);

	// Master set/reset; old value governs bits 3-0 of the same write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			master_set_reset_q <= 1'b0;
		else if (pulse_wr)
			master_set_reset_q <= wbyte[`CTDR_MP_MASTER_SR];                                // [R19]
	end

	// Counter steps and offset reset last one cycle, then clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_step    <= 1'b0;
			bcnt_step    <= 1'b0;
			offset_clear <= 1'b0;
		end
		else
		begin
			addr_step    <= pulse_wr & wbyte[`CTDR_MP_ADDR_CLK];                // [R16]
			bcnt_step    <= pulse_wr & wbyte[`CTDR_MP_BCNT_CLK];                // [R17]
			offset_clear <= (pulse_wr & wbyte[`CTDR_MP_OFF_RESET])
			                | gross_error_in | gross_error_underflow;           // [R18]
		end
	end

	// Forced internal handshake signals
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dma_write_direction <= 1'b0;
			end_of_process      <= 1'b0;
			data_request_force  <= 1'b0;
			data_ack_force_n    <= 1'b1;
		end
		else
		begin
			if (pulse_wr & wbyte[`CTDR_MP_DMA_DIR])
				dma_write_direction <= master_set_reset_q;                                  // [R20]
			// Assert gives a single-cycle pulse; deassert just holds low
			end_of_process <= pulse_wr & wbyte[`CTDR_MP_EOP] & master_set_reset_q;          // [R21]
			if (pulse_wr & wbyte[`CTDR_MP_INTERNAL_DATA_REQUEST])
				data_request_force <= master_set_reset_q;                                   // [R22]
			if (pulse_wr & wbyte[`CTDR_MP_INTERNAL_DATA_ACKNOWLEDGE])
				data_ack_force_n <= ~master_set_reset_q;                                    // [R22]
		end
	end

	// ======================================================================
	// Assertions
	default clocking ast_cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_SOFTWARE_SIGNAL_FLAG_CLEAR: assert property (                                          // [R1]
		rd_acc && sel == ctdr_pkg::CTDR_SEL_HS |=> software_signal_flag_clear && !$past(pwrite))
		else $error("status read did not clear signal flag");

	AST_OFFSET_CMP: assert property (                                          // [R2]
		role_initiator && offset_count == 4'h0 |=> status[`CTDR_HS_OFFSET_CMP])
		else $error("offset compare missed zero count");

	AST_SFP_LATCH: assert property (                                           // [R3]
		pop |=> sfp_q == $past(sfifo_mem[rd_ptr_q][8]))
		else $error("fifo parity not latched on readout");

	AST_DFP_LATCH: assert property (                                           // [R4]
		dfifo_rd_stb |=> dfp_q == $past(dfifo_rd_parity))
		else $error("dma fifo parity not latched");

	AST_POP_COUNT: assert property (                                           // [R7]
		pop && !push |=> cnt_q == $past(cnt_q) - 4'h1)
		else $error("readout did not remove a byte");

	AST_UNDERFLOW: assert property (                                           // [R8]
		rd_acc && sel == ctdr_pkg::CTDR_SEL_FIFO && sf_empty
		|=> gross_error_underflow ##1 offset_clear)
		else $error("underflow did not raise gross error and offset reset");

	AST_SCSI_FLOAT: assert property (                                          // [R11]
		$rose(mode_q[`CTDR_TM_SCSI_FLOAT]) |=> !scsi_pins_oe)
		else $error("scsi pins not floated");

	AST_EOP_PULSE: assert property (                                           // [R21]
		pulse_wr && wbyte[`CTDR_MP_EOP] && master_set_reset_q |=> end_of_process ##1 !end_of_process)
		else $error("end of process not a single pulse");

	AST_ADDR_STEP: assert property (                                           // [R16]
		addr_step |=> !addr_step || $past(pulse_wr))
		else $error("address step did not self clear");

	AST_INTERNAL_DATA_REQUEST_FORCE: assert property (                                          // [R22]
		pulse_wr && wbyte[`CTDR_MP_INTERNAL_DATA_REQUEST] |=> data_request_force == $past(master_set_reset_q))
		else $error("data request force wrong");

	AST_RO_WRITE: assert property (                                            // [R23]
		wr_acc && sel == ctdr_pkg::CTDR_SEL_FIFO |=> cnt_q == $past(cnt_q)
		|| $past(push))
		else $error("write to readout changed fifo");

	COV_FIFO_READ: cover property (pop ##1 pop);
	COV_UNDERFLOW: cover property (gross_error_underflow);
	COV_LOOPBACK:  cover property (loop_scsi_input_data_latch_load && loopback_enable);
	COV_FULL:      cover property (sf_full ##[1:20] pop);

endmodule

// ===== test/tb.sv
// Purpose: Self-checking bench for the chip test register group
// Assumes: APB slave answers in its own time; side inputs change after rising edges
// Notes:   A monitor counts the one-cycle pulse outputs; tests clear and check them
`timescale 1ns/1ps
`include "ctdr_consts.svh"

module tb;
	// ======================================================================
	// Signals
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
	logic        software_signal_flag_flag, software_signal_flag_clear, role_initiator, true_end_of_process;
	logic        core_data_request, core_data_ack_n, dfifo_rd_stb, dfifo_rd_parity;
	logic        sfifo_push, scsi_output_data_latch_wr_stb, scsi_even_parity, gross_error_in;
	logic        gross_error_underflow, bus_mux_mode, host_pins_oe, scsi_pins_oe;
	logic        scsi_dir_force_low, loopback_enable, loop_scsi_input_data_latch_load, lane_access_en;
	logic        addr_step, bcnt_step, offset_clear, dma_write_direction;
	logic        end_of_process, data_request_force, data_ack_force_n;
	logic [1:0]  lane_select;
	logic [3:0]  offset_count, offset_max, sfifo_count;
	logic [7:0]  paddr, scsi_output_data_latch_wr_data, loop_scsi_input_data_latch_data;
	logic [8:0]  sfifo_push_word;
	logic [31:0] pwdata, prdata, rd;
	int          err_count, compares, pc[7];
	localparam logic [7:0] A_HS = {`CTDR_IDX_HANDSHAKE, 2'b00};
	localparam logic [7:0] A_FF = {`CTDR_IDX_FIFO_READOUT, 2'b00};
	localparam logic [7:0] A_TM = {`CTDR_IDX_TEST_MODE, 2'b00};
	localparam logic [7:0] A_MP = {`CTDR_IDX_PULSE, 2'b00};

	ctdr_regs ctdr_regs_i (.*);

	// Clock
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Pulse monitor; a level stuck high would show as a count above one
	wire [6:0] pv = {end_of_process, offset_clear, bcnt_step, addr_step,
		loop_scsi_input_data_latch_load, gross_error_underflow, software_signal_flag_clear};
	always @(posedge pclk)
		for (int i = 0; i < 7; i++)
			if (pv[i] === 1'b1)
				pc[i]++;

	// ======================================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One APB transfer; request held until pready is sampled high at a rising edge,
	// read data and error taken at that same edge, only then released
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			chk("pready", 32'h1, 32'h0);
			final_report();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk("read data", {24'h0, e}, rd);
	endtask

	task automatic pchk(input int i, input int e);
		chk("pulse count", e, pc[i]);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ======================================================================
	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, software_signal_flag_flag, true_end_of_process} = '0;
		{core_data_request, dfifo_rd_stb, dfifo_rd_parity, sfifo_push, sfifo_push_word} = '0;
		{scsi_output_data_latch_wr_stb, scsi_output_data_latch_wr_data, scsi_even_parity, gross_error_in, offset_count} = '0;
		{offset_max, err_count, compares} = '0;
		role_initiator = 1'b1;
		core_data_ack_n = 1'b1;
		pc = '{default: 0};
		idle(2);
		presetn <= 1'b1;
		// Reset values, then an underflowing readout
		rdchk(A_HS, `CTDR_RST_HANDSHAKE);
		rdchk(A_TM, `CTDR_RST_TEST_MODE);
		rdchk(A_MP, `CTDR_RST_PULSE);
		chk("pin enables", 2'b11, {host_pins_oe, scsi_pins_oe});
		rdchk(A_FF, 8'h00);
		idle(3);
		pchk(1, 1);
		pchk(5, 1);
		$display("test reset done");
		// Status mirrors; target offset compare; signal flag cleared by read
		pc = '{default: 0};
		software_signal_flag_flag <= 1'b1;
		true_end_of_process <= 1'b1;
		core_data_request <= 1'b1;
		core_data_ack_n <= 1'b0;
		role_initiator <= 1'b0;
		offset_count <= 4'h5;
		offset_max <= 4'h5;
		rdchk(A_HS, 8'h66);
		idle(3);
		pchk(0, 1);
		software_signal_flag_flag <= 1'b0;
		true_end_of_process <= 1'b0;
		core_data_request <= 1'b0;
		core_data_ack_n <= 1'b1;
		offset_count <= 4'h4;
		apb(1'b1, A_HS, 8'hff);
		apb(1'b1, A_FF, 8'hff);
		rdchk(A_HS, 8'h01);
		$display("test status done");
		// SCSI FIFO pops with parity; DMA FIFO parity latch
		@(posedge pclk);
		sfifo_push <= 1'b1;
		sfifo_push_word <= 9'h1a5;
		@(posedge pclk);
		sfifo_push_word <= 9'h03c;
		@(posedge pclk);
		sfifo_push <= 1'b0;
		idle(1);
		chk("fifo count", 4'h2, sfifo_count);
		rdchk(A_FF, 8'ha5);
		rdchk(A_HS, 8'h11);
		rdchk(A_FF, 8'h3c);
		rdchk(A_HS, 8'h01);
		dfifo_rd_parity <= 1'b1;
		dfifo_rd_stb <= 1'b1;
		@(posedge pclk);
		dfifo_rd_stb <= 1'b0;
		dfifo_rd_parity <= 1'b0;
		rdchk(A_HS, 8'h09);
		$display("test fifo done");
		// Mode bits and every lane select code
		for (int l = 0; l < 8; l++)
		begin
			apb(1'b1, A_TM, 8'h98 | l[7:0]);
			rdchk(A_TM, 8'h98 | l[7:0]);
			chk("mode outs", {2'b11, l[2:0]}, {bus_mux_mode, loopback_enable, lane_access_en, lane_select});
		end
		// Redirected output latch writes, odd then even parity, with loopback
		pc = '{default: 0};
		for (int p = 0; p < 2; p++)
		begin
			scsi_even_parity <= p[0];
			scsi_output_data_latch_wr_data <= 8'h07;
			scsi_output_data_latch_wr_stb <= 1'b1;
			@(posedge pclk);
			scsi_output_data_latch_wr_stb <= 1'b0;
			idle(2);
			chk("loop byte", 8'h07, loop_scsi_input_data_latch_data);
			rdchk(A_FF, 8'h07);
			rdchk(A_HS, {3'b000, (p[0] ? ^8'h07 : ~^8'h07), 4'h9});
		end
		pchk(2, 2);
		// Pin controls follow the mode register one cycle late
		apb(1'b1, A_TM, 8'h40);
		idle(2);
		chk("float all", 3'b000, {host_pins_oe, scsi_pins_oe, scsi_dir_force_low});
		apb(1'b1, A_TM, 8'h20);
		idle(2);
		chk("float scsi", 3'b101, {host_pins_oe, scsi_pins_oe, scsi_dir_force_low});
		apb(1'b1, A_TM, 8'h00);
		idle(2);
		chk("no float", 3'b110, {host_pins_oe, scsi_pins_oe, scsi_dir_force_low});
		$display("test mode done");
		// Self-clearing steps, gross error, set and reset of forced signals
		pc = '{default: 0};
		apb(1'b1, A_MP, 8'he0);
		@(posedge pclk);
		gross_error_in <= 1'b1;
		@(posedge pclk);
		gross_error_in <= 1'b0;
		idle(3);
		pchk(3, 1);
		pchk(4, 1);
		pchk(5, 2);
		rdchk(A_MP, 8'h00);
		apb(1'b1, A_MP, 8'h10);
		apb(1'b1, A_MP, 8'h1f);
		idle(2);
		chk("forced set", 3'b110, {dma_write_direction, data_request_force, data_ack_force_n});
		pchk(6, 1);
		// Scsi parity bit still holds the even-parity byte popped earlier
		rdchk(A_HS, 8'h1a);
		rdchk(A_MP, 8'h10);
		apb(1'b1, A_MP, 8'h00);
		apb(1'b1, A_MP, 8'h0f);
		idle(2);
		chk("forced clear", 3'b001, {dma_write_direction, data_request_force, data_ack_force_n});
		pchk(6, 1);
		apb(1'b0, 8'h68, 8'h00);
		chk("unmapped error", 1'b1, se);
		$display("test pulse done");
		final_report();
	end
endmodule
